/* File: hw/cca_pkg.sv */
// constants shared by the counter array compare and watchdog block
// What this block does
// RULE_01 - software timer: 16-bit counter equals compare sets match flag, irq if enabled
// RULE_02 - match flag stays set until software clears it
// RULE_03 - mode chosen from compare, match, toggle, pulse and wide select bits
// RULE_04 - low compare write clears compare enable, high compare write sets it
// RULE_05 - toggle mode inverts module pin on every 16-bit match
// RULE_06 - entering toggle mode sets toggle output to one
// RULE_07 - frequency mode: low byte match toggles pin, adds high byte to low byte
// RULE_08 - frequency high byte zero gives a 256 tick half period
// RULE_09 - 8-bit pwm: pin high on low byte match, low on low byte overflow
// RULE_10 - 8-bit pwm reloads low compare from high compare on low byte wrap
// RULE_11 - pwm with compare enable cleared gives constant zero output
// RULE_12 - 16-bit pwm: pin high on 16-bit match, low on counter overflow
// RULE_13 - software times 16-bit pwm updates to match interrupts
// RULE_14 - watchdog enable makes module 5 a watchdog comparing high bytes
// RULE_15 - watchdog on: counter runs, counter writes and select bits frozen, module 5 locked
// RULE_16 - watchdog on: run bit reads only what software set
// RULE_17 - watchdog on: write to module 5 high loads counter high plus offset
// RULE_18 - watchdog reset on low byte overflow while module 5 high equals counter high
// RULE_19 - writing one to module 5 match flag while watchdog on resets at once
// RULE_20 - enable or lock bit enables watchdog; lock holds until system reset
// RULE_21 - after reset watchdog on, timebase divide by 12, low bytes zero
// RULE_22 - counter increments per tick, wrap sets overflow flag and irq if enabled
// RULE_23 - 3-bit timebase select picks one of seven counting sources
// RULE_24 - matches are evaluated once per timebase tick
// RULE_25 - pin outputs are registered, changing the cycle after the event
package cca_pkg;
	localparam int NUM_MODULES = 6;
	localparam int WDOG_MODULE = 5;
	// register addresses of the plain port
	localparam logic [4:0] ADDR_CONTROL   = 5'h00;
	localparam logic [4:0] ADDR_MODE      = 5'h01;
	localparam logic [4:0] ADDR_CNT_LOW   = 5'h02;
	localparam logic [4:0] ADDR_CNT_HIGH  = 5'h03;
	localparam logic [4:0] ADDR_CMP_LOW0  = 5'h08;
	localparam logic [4:0] ADDR_CMP_HIGH0 = 5'h10;
	localparam logic [4:0] ADDR_MMODE0    = 5'h18;
	// counter_control_reg fields
	localparam int CTL_OVF_BIT = 7;
	localparam int CTL_RUN_BIT = 6;
	// counter_mode_reg fields
	localparam int MD_IDLE_BIT = 7;
	localparam int MD_WDE_BIT  = 6;
	localparam int MD_LCK_BIT  = 5;
	localparam int MD_TBS_LSB  = 1;
	localparam int MD_OIE_BIT  = 0;
	// module mode fields
	localparam int MM_WIDE_BIT = 7;
	localparam int MM_CEN_BIT  = 6;
	localparam int MM_MAT_BIT  = 3;
	localparam int MM_TOG_BIT  = 2;
	localparam int MM_PWM_BIT  = 1;
	localparam int MM_IE_BIT   = 0;
	// timebase sources
	localparam logic [2:0] TB_DIV12 = 3'h0;
	localparam logic [2:0] TB_DIV4  = 3'h1;
	localparam logic [2:0] TB_T0    = 3'h2;
	localparam logic [2:0] TB_EXT   = 3'h3;
	localparam logic [2:0] TB_SYS   = 3'h4;
	localparam logic [2:0] TB_OSC8  = 3'h5;
	localparam logic [2:0] TB_RTC8  = 3'h6;
	localparam logic [3:0] DIV12_LAST = 4'hB;
	localparam logic [3:0] DIV4_LAST  = 4'h3;
	localparam logic [2:0] DIV8_LAST  = 3'h7;
	localparam logic [7:0] BYTE_MAX   = 8'hFF;
	localparam logic [7:0] BYTE_ZERO  = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h40;
	typedef enum logic [2:0] {
		CCA_IDLE_MODE, CCA_TIMER, CCA_TOGGLE, CCA_FREQ, CCA_PWM8, CCA_PWM16
	} cca_mode_t;
endpackage

/* File: hw/cca_counter_array.sv */
// counter array with six compare modules and module 5 watchdog
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module cca_counter_array
	import cca_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic [4:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	output logic [7:0]      reg_rdata,
	input  wire logic       timer0_overflow,
	input  wire logic       ext_count_in,
	input  wire logic       ext_osc_tick,
	input  wire logic       rtc_tick,
	input  wire logic       cpu_idle,
	output logic [5:0]      module_pin,
	output logic            irq,
	output logic            watchdog_reset
);
	logic [15:0] count_reg;
	logic [7:0]  cmp_low_reg  [NUM_MODULES];
	logic [7:0]  cmp_high_reg [NUM_MODULES];
	logic [7:0]  mmode_reg    [NUM_MODULES];
	logic [5:0]  match_flag_reg;
	logic        overflow_flag_reg;
	logic        run_reg;
	logic        idle_halt_reg;
	logic        wdog_enable_reg;
	logic        wdog_lock_reg;
	logic [2:0]  timebase_select_reg;
	logic        ovf_irq_enable_reg;
	logic [3:0]  div12_reg;
	logic [3:0]  div4_reg;
	logic [2:0]  osc_div_reg;
	logic [2:0]  rtc_div_reg;
	logic        ext_prev_reg;
	logic [7:0]  snap_reg;
	logic [5:0]  prev_toggle_mode_reg;
	logic        tick;
	logic        wdog_on;
	logic        counting;
	logic        low_wrap;
	logic        full_wrap;
	logic        is_wr;
	logic [2:0]  wr_idx;
	cca_mode_t   mode [NUM_MODULES];

	assign wdog_on   = wdog_enable_reg | wdog_lock_reg; // RULE_20
	assign counting  = (run_reg | wdog_on) & ~(idle_halt_reg & cpu_idle); // RULE_15
	assign is_wr     = reg_write;
	assign wr_idx    = reg_addr[2:0];
	assign low_wrap  = tick & (count_reg[7:0] == BYTE_MAX);
	assign full_wrap = tick & (count_reg == 16'hFFFF);

	// timebase prescalers run freely so a source change takes effect quickly
	always_ff @(posedge core_clk) begin
		if (reset) begin
			div12_reg    <= '0;
			div4_reg     <= '0;
			osc_div_reg  <= '0;
			rtc_div_reg  <= '0;
			ext_prev_reg <= 1'b0;
		end else begin
			div12_reg    <= (div12_reg == DIV12_LAST) ? 4'h0 : div12_reg + 4'h1;
			div4_reg     <= (div4_reg == DIV4_LAST) ? 4'h0 : div4_reg + 4'h1;
			osc_div_reg  <= osc_div_reg + {2'h0, ext_osc_tick};
			rtc_div_reg  <= rtc_div_reg + {2'h0, rtc_tick};
			ext_prev_reg <= ext_count_in;
		end
	end

	always_comb begin // RULE_23
		case (timebase_select_reg)
			TB_DIV12: tick = (div12_reg == DIV12_LAST);
			TB_DIV4:  tick = (div4_reg == DIV4_LAST);
			TB_T0:    tick = timer0_overflow;
			TB_EXT:   tick = ext_prev_reg & ~ext_count_in;
			TB_SYS:   tick = 1'b1;
			TB_OSC8:  tick = ext_osc_tick & (osc_div_reg == DIV8_LAST);
			TB_RTC8:  tick = rtc_tick & (rtc_div_reg == DIV8_LAST);
			default:  tick = 1'b0;
		endcase
		tick = tick & counting;
	end

	// mode decode; module 5 is forced to software timer under the watchdog
	always_comb begin
		for (int i = 0; i < NUM_MODULES; i++) begin
			logic [7:0] m;
			m = mmode_reg[i];
			if (i == WDOG_MODULE && wdog_on)
				mode[i] = CCA_TIMER; // RULE_15
			else if (m[MM_CEN_BIT] && m[MM_TOG_BIT] && m[MM_PWM_BIT])
				mode[i] = CCA_FREQ; // RULE_03
			else if (m[MM_CEN_BIT] && m[MM_PWM_BIT])
				mode[i] = m[MM_WIDE_BIT] ? CCA_PWM16 : CCA_PWM8;
			else if (m[MM_CEN_BIT] && m[MM_MAT_BIT])
				mode[i] = m[MM_TOG_BIT] ? CCA_TOGGLE : CCA_TIMER;
			else if (m[MM_PWM_BIT])
				mode[i] = m[MM_WIDE_BIT] ? CCA_PWM16 : CCA_PWM8; // RULE_11
			else
				mode[i] = CCA_IDLE_MODE;
		end
	end

	// shared counter; writes refused while the watchdog is on
	always_ff @(posedge core_clk) begin
		if (reset) begin
			count_reg <= '0; // RULE_21
		end else if (is_wr && reg_addr == ADDR_CNT_LOW && !wdog_on) begin
			count_reg[7:0] <= reg_wdata;
		end else if (is_wr && reg_addr == ADDR_CNT_HIGH && !wdog_on) begin
			count_reg[15:8] <= reg_wdata; // RULE_15
		end else if (tick) begin
			count_reg <= count_reg + 16'h1; // RULE_22
		end
	end

	// control and mode bits
	always_ff @(posedge core_clk) begin
		if (reset) begin
			run_reg             <= 1'b0;
			idle_halt_reg       <= 1'b0;
			wdog_enable_reg     <= 1'b1; // RULE_21
			wdog_lock_reg       <= 1'b0;
			timebase_select_reg <= TB_DIV12;
			ovf_irq_enable_reg  <= 1'b0;
		end else if (is_wr && reg_addr == ADDR_CONTROL) begin
			run_reg <= reg_wdata[CTL_RUN_BIT]; // RULE_16
		end else if (is_wr && reg_addr == ADDR_MODE) begin
			wdog_enable_reg    <= reg_wdata[MD_WDE_BIT];
			wdog_lock_reg      <= wdog_lock_reg | reg_wdata[MD_LCK_BIT]; // RULE_20
			ovf_irq_enable_reg <= reg_wdata[MD_OIE_BIT];
			if (!wdog_on) begin
				idle_halt_reg       <= reg_wdata[MD_IDLE_BIT]; // RULE_15
				timebase_select_reg <= reg_wdata[MD_TBS_LSB +: 3];
			end
		end
	end

	// flags: hardware set wins over a software clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (reset) begin
			overflow_flag_reg <= 1'b0;
			match_flag_reg    <= '0;
		end else begin
			for (int i = 0; i < NUM_MODULES; i++) begin
				logic hit;
				hit = 1'b0;
				if (mode[i] == CCA_TIMER && mmode_reg[i][MM_MAT_BIT] | (i == WDOG_MODULE))
					hit = tick && count_reg == {cmp_high_reg[i], cmp_low_reg[i]}; // RULE_01
				if ((mode[i] == CCA_TOGGLE || mode[i] == CCA_PWM16)
				    && mmode_reg[i][MM_MAT_BIT])
					hit = tick && count_reg == {cmp_high_reg[i], cmp_low_reg[i]}; // RULE_24
				if (is_wr && reg_addr == ADDR_CONTROL)
					match_flag_reg[i] <= reg_wdata[i] | hit;
				else
					match_flag_reg[i] <= match_flag_reg[i] | hit; // RULE_02
			end
			if (is_wr && reg_addr == ADDR_CONTROL)
				overflow_flag_reg <= reg_wdata[CTL_OVF_BIT] | full_wrap;
			else
				overflow_flag_reg <= overflow_flag_reg | full_wrap; // RULE_22
		end
	end

	// compare registers and per-module mode
	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int i = 0; i < NUM_MODULES; i++) begin
				cmp_low_reg[i]  <= BYTE_ZERO; // RULE_21
				cmp_high_reg[i] <= BYTE_ZERO;
				mmode_reg[i]    <= (i == WDOG_MODULE) ? MODE_RESET : BYTE_ZERO;
			end
		end else begin
			for (int i = 0; i < NUM_MODULES; i++) begin
				logic wr_lo;
				logic wr_hi;
				logic wr_md;
				wr_lo = is_wr && reg_addr[4:3] == ADDR_CMP_LOW0[4:3] && wr_idx == i[2:0];
				wr_hi = is_wr && reg_addr[4:3] == ADDR_CMP_HIGH0[4:3] && wr_idx == i[2:0];
				wr_md = is_wr && reg_addr[4:3] == ADDR_MMODE0[4:3] && wr_idx == i[2:0];
				if (wr_md && !(i == WDOG_MODULE && wdog_on))
					mmode_reg[i] <= reg_wdata; // RULE_15
				else if (wr_lo)
					mmode_reg[i][MM_CEN_BIT] <= 1'b0; // RULE_04
				else if (wr_hi)
					mmode_reg[i][MM_CEN_BIT] <= 1'b1; // RULE_04
				if (wr_lo)
					cmp_low_reg[i] <= reg_wdata;
				else if (mode[i] == CCA_FREQ && tick && count_reg[7:0] == cmp_low_reg[i])
					cmp_low_reg[i] <= cmp_low_reg[i] + cmp_high_reg[i]; // RULE_07 RULE_08
				else if (mode[i] == CCA_PWM8 && low_wrap)
					cmp_low_reg[i] <= cmp_high_reg[i]; // RULE_10
				if (wr_hi && i == WDOG_MODULE && wdog_on)
					cmp_high_reg[i] <= count_reg[15:8] + cmp_low_reg[i]; // RULE_17
				else if (wr_hi)
					cmp_high_reg[i] <= reg_wdata;
			end
		end
	end

	// module pins, registered so they move the cycle after the event
	always_ff @(posedge core_clk) begin
		if (reset) begin
			module_pin           <= '0;
			prev_toggle_mode_reg <= '0;
		end else begin
			for (int i = 0; i < NUM_MODULES; i++) begin
				logic m16;
				logic m8;
				logic cen;
				m16 = tick && count_reg == {cmp_high_reg[i], cmp_low_reg[i]};
				m8  = tick && count_reg[7:0] == cmp_low_reg[i];
				cen = mmode_reg[i][MM_CEN_BIT];
				prev_toggle_mode_reg[i] <= (mode[i] == CCA_TOGGLE);
				unique case (mode[i])
					CCA_TOGGLE: begin
						if (!prev_toggle_mode_reg[i])
							module_pin[i] <= 1'b1; // RULE_06
						else if (m16)
							module_pin[i] <= ~module_pin[i]; // RULE_05 RULE_25
					end
					CCA_FREQ: begin
						if (m8)
							module_pin[i] <= ~module_pin[i]; // RULE_07
					end
					CCA_PWM8: begin
						if (!cen || low_wrap)
							module_pin[i] <= 1'b0; // RULE_09 RULE_11
						else if (m8)
							module_pin[i] <= 1'b1; // RULE_09
					end
					CCA_PWM16: begin
						if (!cen || full_wrap)
							module_pin[i] <= 1'b0; // RULE_12 RULE_11
						else if (m16)
							module_pin[i] <= 1'b1; // RULE_12
					end
					CCA_TIMER, CCA_IDLE_MODE: begin
						module_pin[i] <= module_pin[i];
					end
				endcase
			end
		end
	end

	// watchdog reset pulse and interrupt line
	always_ff @(posedge core_clk) begin
		if (reset) begin
			watchdog_reset <= 1'b0;
			irq            <= 1'b0;
		end else begin
			watchdog_reset <= wdog_on && ((low_wrap
				&& cmp_high_reg[WDOG_MODULE] == count_reg[15:8]) // RULE_14 RULE_18
				|| (is_wr && reg_addr == ADDR_CONTROL && reg_wdata[WDOG_MODULE])); // RULE_19
			irq <= (overflow_flag_reg & ovf_irq_enable_reg) | (|(match_flag_reg
				& {mmode_reg[5][MM_IE_BIT], mmode_reg[4][MM_IE_BIT],
				   mmode_reg[3][MM_IE_BIT], mmode_reg[2][MM_IE_BIT],
				   mmode_reg[1][MM_IE_BIT], mmode_reg[0][MM_IE_BIT]})); // RULE_01
		end
	end

	// read port; reading counter low latches counter high for a coherent pair
	always_ff @(posedge core_clk) begin
		if (reset) begin
			reg_rdata <= '0;
			snap_reg  <= '0;
		end else if (reg_read) begin
			reg_rdata <= '0;
			if (reg_addr == ADDR_CONTROL)
				reg_rdata <= {overflow_flag_reg, run_reg, match_flag_reg}; // RULE_16
			else if (reg_addr == ADDR_MODE)
				reg_rdata <= {idle_halt_reg, wdog_enable_reg, wdog_lock_reg, 1'b0,
				              timebase_select_reg, ovf_irq_enable_reg};
			else if (reg_addr == ADDR_CNT_LOW) begin
				reg_rdata <= count_reg[7:0];
				snap_reg  <= count_reg[15:8];
			end else if (reg_addr == ADDR_CNT_HIGH)
				reg_rdata <= snap_reg;
			else if (wr_idx < 3'(NUM_MODULES) && reg_addr[4:3] == ADDR_CMP_LOW0[4:3])
				reg_rdata <= cmp_low_reg[wr_idx];
			else if (wr_idx < 3'(NUM_MODULES) && reg_addr[4:3] == ADDR_CMP_HIGH0[4:3])
				reg_rdata <= cmp_high_reg[wr_idx];
			else if (wr_idx < 3'(NUM_MODULES) && reg_addr[4:3] == ADDR_MMODE0[4:3])
				reg_rdata <= mmode_reg[wr_idx];
		end else begin
			reg_rdata <= '0;
		end
	end

	a_wdog_force_reset: assert property (@(posedge core_clk) disable iff (reset)
		wdog_on && reg_write && reg_addr == ADDR_CONTROL && reg_wdata[WDOG_MODULE]
		|=> watchdog_reset) // RULE_19
		else $error("forced watchdog reset missing");
	a_wdog_expire: assert property (@(posedge core_clk) disable iff (reset)
		wdog_on && low_wrap && cmp_high_reg[WDOG_MODULE] == count_reg[15:8]
		|=> watchdog_reset) // RULE_18
		else $error("watchdog expiry missed");
	a_flag_sticky: assert property (@(posedge core_clk) disable iff (reset)
		match_flag_reg[0] && !(reg_write && reg_addr == ADDR_CONTROL)
		|=> match_flag_reg[0]) // RULE_02
		else $error("match flag dropped");
	a_overflow_set: assert property (@(posedge core_clk) disable iff (reset)
		full_wrap |=> overflow_flag_reg && count_reg == 16'h0000) // RULE_22
		else $error("overflow not flagged");
	a_count_frozen: assert property (@(posedge core_clk) disable iff (reset)
		wdog_on && !tick |=> count_reg == $past(count_reg)) // RULE_15
		else $error("counter written under watchdog");
	a_high_enables: assert property (@(posedge core_clk) disable iff (reset)
		reg_write && reg_addr == ADDR_CMP_HIGH0 |=> mmode_reg[0][MM_CEN_BIT]) // RULE_04
		else $error("compare enable not set");
	a_pwm8_low: assert property (@(posedge core_clk) disable iff (reset)
		mode[0] == CCA_PWM8 && low_wrap |=> !module_pin[0]) // RULE_09
		else $error("pwm8 not low after wrap");
	a_wdog_update: assert property (@(posedge core_clk) disable iff (reset)
		wdog_on && reg_write && reg_addr == (ADDR_CMP_HIGH0 | 5'h05)
		|=> cmp_high_reg[WDOG_MODULE] == $past(count_reg[15:8]) + cmp_low_reg[WDOG_MODULE])
		// RULE_17
		else $error("watchdog update wrong");
	a_lock_holds: assert property (@(posedge core_clk) disable iff (reset)
		wdog_lock_reg |=> wdog_on) // RULE_20
		else $error("lock released");
endmodule

/* File: verif/test_cca_counter_array.sv */
// self-checking bench for the counter array compare, pwm and watchdog block
`timescale 1ns/1ps
module test_cca_counter_array;
	import cca_pkg::*;
	logic       core_clk;
	logic       reset;
	logic [4:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_write;
	logic       reg_read;
	logic [7:0] reg_rdata;
	logic [5:0] module_pin;
	logic       irq;
	logic       watchdog_reset;
	int         mismatches;
	int         checks_done;
	int         cyc;
	int         wd_pulses;
	int         base;
	int         hi;
	int         tg;
	logic [7:0] d;

	// the alternate timebase sources stay quiet; only the system clock and /12 are used
	cca_counter_array u_dut (
		.core_clk        (core_clk),
		.reset           (reset),
		.reg_addr        (reg_addr),
		.reg_wdata       (reg_wdata),
		.reg_write       (reg_write),
		.reg_read        (reg_read),
		.reg_rdata       (reg_rdata),
		.timer0_overflow (1'b0),
		.ext_count_in    (1'b0),
		.ext_osc_tick    (1'b0),
		.rtc_tick        (1'b0),
		.cpu_idle        (1'b0),
		.module_pin      (module_pin),
		.irq             (irq),
		.watchdog_reset  (watchdog_reset)
	);

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		if (reset) cyc <= 0;
		else cyc <= cyc + 1;
		if (watchdog_reset === 1'b1) wd_pulses <= wd_pulses + 1;
	end

	task automatic stop_test;
		if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (exp !== got) begin
			$display("FAIL %s expected %h seen %h", name, exp, got);
			mismatches++;
		end
	endtask

	// counts from pin activity tolerate the pipeline delay at both ends of a window
	task automatic near(input string name, input int exp, input int got, input int tol);
		checks_done++;
		if (got < exp - tol || got > exp + tol) begin
			$display("FAIL %s expected %0d seen %0d", name, exp, got);
			mismatches++;
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge core_clk);
		reg_write <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, output logic [7:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge core_clk);
		reg_read <= 1'b0;
		#1 v = reg_rdata;
	endtask

	task automatic measure(input int idx, input int n);
		logic prev;
		hi = 0;
		tg = 0;
		prev = module_pin[idx];
		repeat (n) begin
			@(posedge core_clk);
			#1;
			if (module_pin[idx] === 1'b1) hi++;
			if (module_pin[idx] !== prev) tg++;
			prev = module_pin[idx];
		end
	endtask

	task automatic do_reset;
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
	endtask

	task automatic wait_pulse(input int limit);
		int n;
		n = 0;
		while (wd_pulses == base && n < limit) begin
			@(posedge core_clk);
			n++;
		end
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		mismatches++;
		stop_test();
	end

	initial begin
		reset = 1'b1;
		reg_addr = 5'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
		mismatches = 0;
		checks_done = 0;
		wd_pulses = 0;
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		base = wd_pulses;
		rd(ADDR_MODE, d); check("mode after reset", 16'h0040, {8'h00, d});
		rd(ADDR_MMODE0 + 5'h05, d); check("module5 mode reset", 16'h0040, {8'h00, d});
		rd(ADDR_CMP_LOW0 + 5'h05, d); check("offset byte reset", 16'h0000, {8'h00, d});
		rd(ADDR_CONTROL, d); check("run bit under watchdog", 16'h0000, {15'h0000, d[6]});
		wr(ADDR_MODE, 8'h48);
		rd(ADDR_MODE, d); check("timebase frozen", 16'h0040, {8'h00, d});
		wr(ADDR_MMODE0 + 5'h05, 8'h00);
		rd(ADDR_MMODE0 + 5'h05, d); check("module5 mode locked", 16'h0040, {8'h00, d});
		wr(ADDR_CNT_HIGH, 8'h77);
		rd(ADDR_CNT_LOW, d);
		rd(ADDR_CNT_HIGH, d); check("counter write ignored", 16'h0000, {8'h00, d});
		wait_pulse(4000);
		near("default timeout cycles", 3072, cyc, 4);
		do_reset();
		base = wd_pulses;
		wr(ADDR_CMP_LOW0 + 5'h05, 8'h02);
		wr(ADDR_CMP_HIGH0 + 5'h05, 8'hA5);
		rd(ADDR_CMP_HIGH0 + 5'h05, d); check("update loads high plus offset", 16'h0002, {8'h00, d});
		repeat (3500) @(posedge core_clk);
		check("no reset after update", 16'h0000, {15'h0000, wd_pulses != base});
		wr(ADDR_CONTROL, 8'h20);
		repeat (2) @(posedge core_clk);
		check("forced reset", 16'h0001, {15'h0000, wd_pulses != base});
		do_reset();
		// watchdog off, counter stopped and zeroed so every match time is known
		// the timebase stays frozen on the write that turns the watchdog off
		wr(ADDR_MODE, 8'h00);
		wr(ADDR_MODE, 8'h08);
		rd(ADDR_MODE, d); check("watchdog disabled", 16'h0008, {8'h00, d});
		wr(ADDR_CONTROL, 8'h00);
		wr(ADDR_CNT_LOW, 8'h00);
		wr(ADDR_CNT_HIGH, 8'h00);
		wr(ADDR_MMODE0, 8'h49);
		wr(ADDR_CMP_LOW0, 8'h10);
		rd(ADDR_MMODE0, d); check("low write clears enable", 16'h0009, {8'h00, d});
		wr(ADDR_CMP_HIGH0, 8'h00);
		rd(ADDR_MMODE0, d); check("high write sets enable", 16'h0049, {8'h00, d});
		wr(ADDR_CMP_LOW0 + 5'h01, 8'h30);
		wr(ADDR_CMP_HIGH0 + 5'h01, 8'h00);
		wr(ADDR_MMODE0 + 5'h01, 8'h4C);
		wr(ADDR_CMP_LOW0 + 5'h02, 8'h00);
		wr(ADDR_CMP_HIGH0 + 5'h02, 8'h04);
		wr(ADDR_MMODE0 + 5'h02, 8'h46);
		wr(ADDR_CMP_LOW0 + 5'h03, 8'hC0);
		wr(ADDR_CMP_HIGH0 + 5'h03, 8'hC0);
		wr(ADDR_MMODE0 + 5'h03, 8'h42);
		check("toggle starts high", 16'h0001, {15'h0000, module_pin[1]});
		wr(ADDR_CONTROL, 8'h40);
		measure(2, 64);
		near("freq toggles", 16, tg, 1);
		check("toggle on match", 16'h0000, {15'h0000, module_pin[1]});
		measure(3, 512);
		near("pwm8 high cycles", 128, hi, 2);
		rd(ADDR_CONTROL, d); check("match flag held", 16'h0001, {15'h0000, d[0]});
		check("irq on match", 16'h0001, {15'h0000, irq});
		wr(ADDR_CONTROL, 8'h40);
		rd(ADDR_CONTROL, d); check("match flag cleared", 16'h0000, {15'h0000, d[0]});
		check("irq cleared", 16'h0000, {15'h0000, irq});
		wr(ADDR_CMP_LOW0 + 5'h02, 8'h00);
		wr(ADDR_CMP_HIGH0 + 5'h02, 8'h00);
		measure(2, 1024);
		near("freq zero high byte", 4, tg, 1);
		wr(ADDR_CMP_LOW0 + 5'h03, 8'h00);
		measure(3, 512);
		check("pwm8 disabled", 16'h0000, hi[15:0]);
		wr(ADDR_CONTROL, 8'h00);
		wr(ADDR_CNT_LOW, 8'h00);
		wr(ADDR_CNT_HIGH, 8'hFF);
		wr(ADDR_CMP_LOW0 + 5'h04, 8'h80);
		wr(ADDR_CMP_HIGH0 + 5'h04, 8'hFF);
		wr(ADDR_MMODE0 + 5'h04, 8'hCB);
		wr(ADDR_CONTROL, 8'h40);
		measure(4, 512);
		near("pwm16 high cycles", 128, hi, 2);
		rd(ADDR_CONTROL, d); check("overflow flag", 16'h0001, {15'h0000, d[7]});
		check("pwm16 match flag", 16'h0001, {15'h0000, d[4]});
		wr(ADDR_MODE, 8'h28);
		wr(ADDR_MODE, 8'h08);
		rd(ADDR_MODE, d); check("lock sticky", 16'h0001, {15'h0000, d[5]});
		base = wd_pulses;
		wr(ADDR_CONTROL, 8'h20);
		repeat (2) @(posedge core_clk);
		check("lock keeps watchdog", 16'h0001, {15'h0000, wd_pulses != base});
		stop_test();
	end
endmodule
